// >>> rtl/pfc_pkg.sv
// package: register map, field layout and reset values of the fraction loop config bank
package pfc_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int DEN_W  = 22;

	// register offsets
	localparam logic [7:0] OFS_DEN_BYTE2 = 8'h1E;
	localparam logic [7:0] OFS_DEN_BYTE1 = 8'h1F;
	localparam logic [7:0] OFS_DEN_BYTE0 = 8'h20;
	localparam logic [7:0] OFS_MOD_CTRL  = 8'h21;
	localparam logic [7:0] OFS_LOOP_CTL1 = 8'h22;
	localparam logic [7:0] OFS_LOOP_CTL2 = 8'h23;
	localparam logic [7:0] OFS_FILT_R2   = 8'h24;

	// field layout
	localparam int DEN_HI_LSB  = 16;
	localparam int DEN_MID_LSB = 8;
	localparam int DEN_HI_W    = 6;
	localparam int DITHER_LSB  = 2;
	localparam int ORDER_LSB   = 0;
	localparam int SEL_W       = 2;
	localparam int DOUBLER_BIT = 5;
	localparam int CTL1_RSV_LSB = 6;
	localparam int PUMP_I_LSB  = 0;
	localparam int PUMP_I_W    = 4;
	localparam int DELAY_LSB   = 4;
	localparam int DELAY_W     = 3;
	localparam int THIRD_C_BIT = 2;
	localparam int CTL2_RSV_LSB = 0;

	// reset values
	localparam logic [5:0] RST_DEN_HI   = 6'h00;
	localparam logic [7:0] RST_DEN_BYTE = 8'h00;
	localparam logic [1:0] RST_DITHER   = 2'h3;
	localparam logic [1:0] RST_ORDER    = 2'h0;
	localparam logic       RST_DOUBLER  = 1'b1;
	localparam logic [1:0] RST_CTL1_RSV = 2'h0;
	localparam logic [3:0] RST_PUMP_I   = 4'h8;
	localparam logic [2:0] RST_DELAY    = 3'h0;
	localparam logic       RST_THIRD_C  = 1'b0;
	localparam logic [1:0] RST_CTL2_RSV = 2'h3;
	localparam logic [7:0] RST_FILT_R2  = 8'h08;
	localparam logic [7:0] READ_ZERO    = 8'h00;

	// documented codes
	localparam logic [1:0] DITHER_WEAK = 2'h0;
	localparam logic [1:0] DITHER_OFF  = 2'h3;
	localparam logic [1:0] ORDER_INT   = 2'h0;
	localparam logic [1:0] ORDER_THIRD = 2'h3;
	localparam logic [3:0] PUMP_1P6MA  = 4'h4;
	localparam logic [3:0] PUMP_6P4MA  = 4'h8;

	// settings handed to the fractional modulator
	typedef struct packed {
		logic [DEN_W-1:0] fraction_denominator;
		logic [SEL_W-1:0] order_select;
		logic [SEL_W-1:0] dither_select;
	} pfc_mod_cfg_t;

	// settings handed to the analog loop
	typedef struct packed {
		logic                doubler_enable;
		logic [PUMP_I_W-1:0] pump_current_code;
		logic [DELAY_W-1:0]  pump_delay_code;
		logic                third_cap_enable;
		logic [DATA_W-1:0]   filter_resistor_code;
	} pfc_loop_cfg_t;

endpackage

// >>> rtl/pfc_regs.sv
// fraction loop configuration register bank
//
// Behaviour
// - denominator is 22 bits gathered from three byte registers
// - top denominator byte holds bits 21:16 in 5:0; upper two reserved; resets zero
// - middle denominator byte holds bits 15:8, read/write, resets zero
// - low denominator byte holds bits 7:0, read/write, resets zero
// - modulator dither select in bits 3:2; 0 weak, 3 off; resets 3
// - modulator order select in bits 1:0; 0 integer, 3 third order; resets 0
// - first loop control bit 5 enables reference doubler; resets to 1
// - pump current code bits 3:0 resets 8; host writes only 4 or 8
// - second loop control bits 6:4 hold pump delay code, resets 0
// - second loop control bit 2 enables third filter capacitor; resets 0
// - filter resistor code fills its whole byte, resets 0x08, any code allowed
`timescale 1ns/1ps

module pfc_regs
	import pfc_pkg::*;
(
	input  wire logic              mclk_i,
	input  wire logic              sys_rst_i,
	input  wire logic              wr_en_i,
	input  wire logic              rd_en_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	output logic      [DATA_W-1:0] rdata_o,
	output logic                   rvalid_o,
	output pfc_mod_cfg_t           mod_cfg_o,
	output pfc_loop_cfg_t          loop_cfg_o
);

	logic [DEN_HI_W-1:0] den_hi_reg;
	logic [DATA_W-1:0]   den_mid_reg;
	logic [DATA_W-1:0]   den_lo_reg;
	logic [SEL_W-1:0]    dither_reg;
	logic [SEL_W-1:0]    order_reg;
	logic                doubler_reg;
	logic [1:0]          ctl1_rsv_reg;
	logic [PUMP_I_W-1:0] pump_i_reg;
	logic [DELAY_W-1:0]  delay_reg;
	logic                third_c_reg;
	logic [1:0]          ctl2_rsv_reg;
	logic [DATA_W-1:0]   filt_r2_reg;
	logic [DATA_W-1:0]   rdata_next;

	// ----------------------------------------------------------------
	// fraction denominator
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			den_hi_reg  <= RST_DEN_HI;
			den_mid_reg <= RST_DEN_BYTE;
			den_lo_reg  <= RST_DEN_BYTE;
		end
		else if (wr_en_i)
		begin
			// no shadow copy: a half-written value reaches the modulator
			// top byte, low six bits
			if (addr_i == OFS_DEN_BYTE2)
				den_hi_reg <= wdata_i[DEN_HI_W-1:0];
			if (addr_i == OFS_DEN_BYTE1)
				den_mid_reg <= wdata_i;
			if (addr_i == OFS_DEN_BYTE0)
				den_lo_reg <= wdata_i;
		end
	end

	// ----------------------------------------------------------------
	// modulator control
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			dither_reg <= RST_DITHER;
			order_reg  <= RST_ORDER;
		end
		else if (wr_en_i && addr_i == OFS_MOD_CTRL)
		begin
			dither_reg <= wdata_i[DITHER_LSB +: SEL_W];
			order_reg  <= wdata_i[ORDER_LSB +: SEL_W];
		end
	end

	// ----------------------------------------------------------------
	// loop control
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			doubler_reg  <= RST_DOUBLER;
			ctl1_rsv_reg <= RST_CTL1_RSV;
			pump_i_reg   <= RST_PUMP_I;
		end
		else if (wr_en_i && addr_i == OFS_LOOP_CTL1)
		begin
			doubler_reg  <= wdata_i[DOUBLER_BIT];
			ctl1_rsv_reg <= wdata_i[CTL1_RSV_LSB +: 2];
			pump_i_reg   <= wdata_i[PUMP_I_LSB +: PUMP_I_W];
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			delay_reg    <= RST_DELAY;
			third_c_reg  <= RST_THIRD_C;
			ctl2_rsv_reg <= RST_CTL2_RSV;
		end
		else if (wr_en_i && addr_i == OFS_LOOP_CTL2)
		begin
			delay_reg    <= wdata_i[DELAY_LSB +: DELAY_W];
			third_c_reg  <= wdata_i[THIRD_C_BIT];
			// low pair has a reset value, so stores
			ctl2_rsv_reg <= wdata_i[CTL2_RSV_LSB +: 2];
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			filt_r2_reg <= RST_FILT_R2;
		else if (wr_en_i && addr_i == OFS_FILT_R2)
			filt_r2_reg <= wdata_i;
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	always_comb
	begin
		rdata_next = READ_ZERO;
		// unstored reserved bits read zero
		// bits with no flop keep the zero preset above
		unique case (addr_i)
			OFS_DEN_BYTE2: rdata_next[DEN_HI_W-1:0] = den_hi_reg;
			OFS_DEN_BYTE1: rdata_next = den_mid_reg;
			OFS_DEN_BYTE0: rdata_next = den_lo_reg;
			OFS_MOD_CTRL:
			begin
				rdata_next[DITHER_LSB +: SEL_W] = dither_reg;
				rdata_next[ORDER_LSB +: SEL_W]  = order_reg;
			end
			OFS_LOOP_CTL1:
			begin
				rdata_next[CTL1_RSV_LSB +: 2]       = ctl1_rsv_reg;
				rdata_next[DOUBLER_BIT]             = doubler_reg;
				rdata_next[PUMP_I_LSB +: PUMP_I_W]  = pump_i_reg;
			end
			OFS_LOOP_CTL2:
			begin
				rdata_next[DELAY_LSB +: DELAY_W] = delay_reg;
				rdata_next[THIRD_C_BIT]          = third_c_reg;
				rdata_next[CTL2_RSV_LSB +: 2]    = ctl2_rsv_reg;
			end
			OFS_FILT_R2:   rdata_next = filt_r2_reg;
			default:       rdata_next = READ_ZERO;
		endcase
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			rdata_o  <= READ_ZERO;
			rvalid_o <= 1'b0;
		end
		else
		begin
			// idle cycles return zero so stale data never looks fresh
			rdata_o  <= rd_en_i ? rdata_next : READ_ZERO;
			rvalid_o <= rd_en_i;
		end
	end

	// ----------------------------------------------------------------
	// outputs to modulator and loop
	// ----------------------------------------------------------------
	// registered copy so outputs come from flops; lags the bank by one cycle
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			mod_cfg_o  <= '{fraction_denominator: {RST_DEN_HI, RST_DEN_BYTE, RST_DEN_BYTE},
				order_select: RST_ORDER, dither_select: RST_DITHER};
			loop_cfg_o <= '{doubler_enable: RST_DOUBLER, pump_current_code: RST_PUMP_I,
				pump_delay_code: RST_DELAY, third_cap_enable: RST_THIRD_C,
				filter_resistor_code: RST_FILT_R2};
		end
		else
		begin
			mod_cfg_o.fraction_denominator <= {den_hi_reg, den_mid_reg, den_lo_reg};
			mod_cfg_o.order_select         <= order_reg;
			mod_cfg_o.dither_select        <= dither_reg;
			loop_cfg_o.doubler_enable       <= doubler_reg;
			loop_cfg_o.pump_current_code    <= pump_i_reg;
			loop_cfg_o.pump_delay_code      <= delay_reg;
			loop_cfg_o.third_cap_enable     <= third_c_reg;
			loop_cfg_o.filter_resistor_code <= filt_r2_reg;
		end
	end

endmodule // pfc_regs

// >>> bench/pfc_regs_asserts.sv
// checker: port properties of the fraction loop config bank
`timescale 1ns/1ps
module pfc_regs_asserts
	import pfc_pkg::*;
(
	input wire logic          mclk_i,
	input wire logic          sys_rst_i,
	input wire logic          wr_en_i,
	input wire logic          rd_en_i,
	input wire logic [7:0]    addr_i,
	input wire logic [7:0]    wdata_i,
	input wire logic [7:0]    rdata_o,
	input wire logic          rvalid_o,
	input wire pfc_mod_cfg_t  mod_cfg_o,
	input wire pfc_loop_cfg_t loop_cfg_o
);
	wire logic [21:0] den = mod_cfg_o.fraction_denominator;
	wire logic [3:0]  sel = {mod_cfg_o.dither_select, mod_cfg_o.order_select};
	wire pfc_loop_cfg_t l = loop_cfg_o;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	den_hi_a:
	assert property (wr_en_i && addr_i == 8'h1E |-> ##2 {2'h0, den[21:16]} == ($past(wdata_i, 2) & 8'h3F))
		else $error("den hi");
	den_lo_a:
	assert property (wr_en_i && addr_i == 8'h20 |-> ##2 den[7:0] == $past(wdata_i, 2))
		else $error("den lo");
	mod_sel_a:
	assert property (wr_en_i && addr_i == 8'h21 |-> ##2 {4'h0, sel} == ($past(wdata_i, 2) & 8'h0F))
		else $error("mod sel");
	pump_doubler_a:
	assert property (wr_en_i && addr_i == 8'h22 |-> ##2
		{2'h0, l.doubler_enable, 1'b0, l.pump_current_code} == ($past(wdata_i, 2) & 8'h2F)) else $error("ctl a");
	delay_cap_a:
	assert property (wr_en_i && addr_i == 8'h23 |-> ##2
		{1'b0, l.pump_delay_code, 1'b0, l.third_cap_enable, 2'h0} == ($past(wdata_i, 2) & 8'h74)) else $error("ctl b");
	resistor_code_a:
	assert property (wr_en_i && addr_i == 8'h24 |-> ##2 l.filter_resistor_code == $past(wdata_i, 2))
		else $error("resistor");
	unmapped_read_a:
	assert property (rd_en_i && (addr_i < 8'h1E || addr_i > 8'h24) |=> rvalid_o && rdata_o == 8'h00)
		else $error("unmapped");
	cfg_hold_a:
	assert property (!wr_en_i [*2] |=> $stable(mod_cfg_o) && $stable(loop_cfg_o))
		else $error("cfg moved");
endmodule // pfc_regs_asserts
bind pfc_regs pfc_regs_asserts pfc_regs_asserts_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
	.wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
	.rvalid_o(rvalid_o), .mod_cfg_o(mod_cfg_o), .loop_cfg_o(loop_cfg_o));

// >>> bench/pfc_host_model.sv
// host model: drives the register strobe port
`timescale 1ns/1ps
module pfc_host_model
(
	input  wire logic       mclk_i,
	input  wire logic [7:0] rdata_i,
	input  wire logic       rvalid_i,
	output logic            wr_en_o,
	output logic            rd_en_o,
	output logic [7:0]      addr_o,
	output logic [7:0]      wdata_o
);
	initial {wr_en_o, rd_en_o, addr_o, wdata_o} = 18'h0;
	// released lines flip so a stale value never looks valid
	task automatic wr(input logic [7:0] a, input logic [7:0] x);
		@(posedge mclk_i);
		#1 {wr_en_o, addr_o, wdata_o} = {1'b1, a, x};
		@(posedge mclk_i);
		#1 {wr_en_o, addr_o, wdata_o} = {1'b0, ~a, ~x};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge mclk_i);
		#1 {rd_en_o, addr_o} = {1'b1, a};
		@(posedge mclk_i);
		#1 {rd_en_o, addr_o} = {1'b0, ~a};
		{v, d} = {rvalid_i, rdata_i};
	endtask
endmodule // pfc_host_model

// >>> bench/pfc_regs_tb_top.sv
// testbench: config bank driven through the host model
`timescale 1ns/1ps
module pfc_regs_tb_top
	import pfc_pkg::*;
;
	logic          mclk_i = 1'b0;
	logic          sys_rst_i = 1'b1;
	logic          wr_en_i, rd_en_i, rvalid_o, v;
	logic [7:0]    addr_i, wdata_i, rdata_o, d;
	pfc_mod_cfg_t  mod_cfg_o;
	pfc_loop_cfg_t loop_cfg_o;
	int            bad_count = 0, n_checks = 0, cyc = 0;
	logic [7:0]    rst_tab [7] = '{8'h00, 8'h00, 8'h00, 8'h0C, 8'h28, 8'h03, 8'h08};
	logic [7:0]    one_tab [7] = '{8'h3F, 8'hFF, 8'hFF, 8'h0F, 8'hE4, 8'h77, 8'hFF};
	logic [7:0]    pat_tab [7] = '{8'hC1, 8'h23, 8'h45, 8'h00, 8'h08, 8'h00, 8'h40};
	initial forever #10 mclk_i = ~mclk_i;
	pfc_regs pfc_regs_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
		.mod_cfg_o(mod_cfg_o), .loop_cfg_o(loop_cfg_o));
	pfc_host_model pfc_host_model_inst (.mclk_i(mclk_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o),
		.wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .addr_o(addr_i), .wdata_o(wdata_i));
	task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
		pfc_host_model_inst.rd(a, d, v);
		n_checks++;
		if ({v, d} !== {1'b1, e}) bad_count++;
		if ({v, d} !== {1'b1, e}) $display("BAD rd %h exp %h got %b %h", a, e, v, d);
	endtask
	task automatic chk_cfg(input logic [42:0] e);
		@(posedge mclk_i);
		#1 n_checks++;
		if ({mod_cfg_o, loop_cfg_o} !== e) bad_count++;
		if ({mod_cfg_o, loop_cfg_o} !== e) $display("BAD cfg exp %h got %h", e, {mod_cfg_o, loop_cfg_o});
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	always @(posedge mclk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 1000) bad_count++;
		if (cyc == 1000) end_sim();
	end
	initial
	begin
		repeat (6) @(posedge mclk_i);
		#1 sys_rst_i = 1'b0;
		chk_cfg({22'h0, 4'h3, 1'b1, 4'h8, 3'h0, 1'b0, 8'h08});
		for (int i = 0; i < 7; i++) chk_rd(8'(30 + i), rst_tab[i]);
		// pump code kept to a legal value
		for (int i = 0; i < 7; i++) pfc_host_model_inst.wr(8'(30 + i), i == 4 ? 8'hF4 : 8'hFF);
		pfc_host_model_inst.wr(8'h25, 8'hFF);
		pfc_host_model_inst.wr(8'h1D, 8'hFF);
		for (int i = 0; i < 7; i++) chk_rd(8'(30 + i), one_tab[i]);
		chk_rd(8'h25, 8'h00);
		chk_rd(8'h1D, 8'h00);
		chk_cfg({22'h3FFFFF, 4'hF, 1'b1, 4'h4, 3'h7, 1'b1, 8'hFF});
		for (int i = 0; i < 7; i++) pfc_host_model_inst.wr(8'(30 + i), pat_tab[i]);
		chk_cfg({22'h012345, 4'h0, 1'b0, 4'h8, 3'h0, 1'b0, 8'h40});
		chk_rd(8'h23, 8'h00);
		@(posedge mclk_i);
		#1 sys_rst_i = 1'b1;
		@(posedge mclk_i);
		#1 sys_rst_i = 1'b0;
		chk_cfg({22'h0, 4'h3, 1'b1, 4'h8, 3'h0, 1'b0, 8'h08});
		end_sim();
	end
endmodule // pfc_regs_tb_top
